// file: hdl/tx_fifo_threshold_burst_ctrl.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module tx_fifo_threshold_burst_ctrl
    import txq_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    // register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // fill side: bus master engine writes bytes
    input  wire logic        FILL_WR,
    input  wire logic [11:0] FILL_BYTES,
    input  wire logic        FILL_PKT_END,
    output logic             FILL_REQ_OK,
    output logic      [8:0]  BURST_WORDS,
    // drain side: transmit engine reads bytes
    input  wire logic        DRAIN_RD,
    input  wire logic [11:0] DRAIN_BYTES,
    input  wire logic        DRAIN_PKT_END,
    output logic             DRAIN_START,
    output logic      [11:0] QUEUE_LEVEL
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] burst_words(input logic [2:0] code);
        if (code == 3'h0) begin
            return BURST_MAX_WORDS;
        end
        return 9'(9'h001 << (code - 3'h1));
    endfunction : burst_words

    function automatic logic [11:0] units_to_bytes(input logic [5:0] units);
        return 12'(units) << UNIT_BYTES_LOG2;
    endfunction : units_to_bytes

    ////////////////////////////////////////////////////////////////////////
    tx_cfg_t     cfg_q;
    logic [11:0] level_q;
    logic [11:0] level_d;
    logic [7:0]  pkts_q;
    logic [7:0]  pkts_d;
    logic [11:0] free_bytes;
    logic [8:0]  burst_words_q;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_q.burst <= TRANSMIT_CONFIG_RST[BURST_LSB +: 3];
            cfg_q.fill  <= TRANSMIT_CONFIG_RST[FILL_LSB +: 6];
            cfg_q.drain <= TRANSMIT_CONFIG_RST[DRAIN_LSB +: 6];
        end else if (REG_WR && REG_ADDR == ADDR_TRANSMIT_CONFIG) begin
            cfg_q.burst <= REG_WDATA[BURST_LSB +: 3];
            cfg_q.fill  <= REG_WDATA[FILL_LSB +: 6];
            cfg_q.drain <= REG_WDATA[DRAIN_LSB +: 6];
        end
    end

    // burst limit loads with the config write so the output comes from a flop
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            burst_words_q <= BURST_MAX_WORDS;
        end else if (REG_WR && REG_ADDR == ADDR_TRANSMIT_CONFIG) begin
            burst_words_q <= burst_words(REG_WDATA[BURST_LSB +: 3]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_TRANSMIT_CONFIG: REG_RDATA <= TRANSMIT_CONFIG_MASK &
                    ({29'h0000_0000, cfg_q.burst} << BURST_LSB |
                     {26'h0000_0000, cfg_q.fill} << FILL_LSB |
                     {26'h0000_0000, cfg_q.drain} << DRAIN_LSB);
                ADDR_QUEUE_STATUS: REG_RDATA <= {12'h000, pkts_q, level_q};
                default: REG_RDATA <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte level and whole-packet count
    always_comb begin
        level_d = level_q;
        if (FILL_WR) begin
            level_d = 12'(level_d + FILL_BYTES);
        end
        if (DRAIN_RD) begin
            level_d = 12'(level_d - DRAIN_BYTES);
        end
        pkts_d = pkts_q;
        if (FILL_WR && FILL_PKT_END) begin
            pkts_d = 8'(pkts_d + 8'h01);
        end
        if (DRAIN_RD && DRAIN_PKT_END && pkts_q != 8'h00) begin
            pkts_d = 8'(pkts_d - 8'h01);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            level_q <= 12'h000;
            pkts_q  <= 8'h00;
        end else begin
            level_q <= level_d;
            pkts_q  <= pkts_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign free_bytes  = 12'(QUEUE_CAPACITY - level_q);
    assign FILL_REQ_OK = free_bytes >= units_to_bytes(cfg_q.fill);
    assign BURST_WORDS = burst_words_q;
    assign DRAIN_START = (level_q >= units_to_bytes(cfg_q.drain)) ||
                         (pkts_q != 8'h00);
    assign QUEUE_LEVEL = level_q;

    ////////////////////////////////////////////////////////////////////////
    property p_fill_gate;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        FILL_REQ_OK |-> (13'(level_q) + 13'({cfg_q.fill, 5'h00}) <= 13'h0800);
    endproperty
    a_fill_gate: assert property (p_fill_gate) else $error("fill gate early");

    property p_fill_units;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        !FILL_REQ_OK |-> (13'(level_q) + 13'({cfg_q.fill, 5'h00}) > 13'h0800);
    endproperty
    a_fill_units: assert property (p_fill_units) else $error("fill units wrong");

    property p_burst_max;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (cfg_q.burst == 3'h0) |-> (BURST_WORDS == 9'h080);
    endproperty
    a_burst_max: assert property (p_burst_max) else $error("burst 000 not 128");

    property p_burst_pow;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (cfg_q.burst == 3'h4) |-> (BURST_WORDS == 9'h008);
    endproperty
    a_burst_pow: assert property (p_burst_pow) else $error("burst 100 not 8");

    property p_drain_level;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (level_q[11:5] >= 7'(cfg_q.drain)) |-> DRAIN_START;
    endproperty
    a_drain_level: assert property (p_drain_level) else $error("no drain start");

    property p_drain_pkt;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (FILL_WR && FILL_PKT_END && !DRAIN_RD) |=> DRAIN_START;
    endproperty
    a_drain_pkt: assert property (p_drain_pkt) else $error("whole packet ignored");

    property p_drain_hold;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        DRAIN_START |-> (level_q[11:5] >= 7'(cfg_q.drain) || pkts_q != 8'h00);
    endproperty
    a_drain_hold: assert property (p_drain_hold) else $error("drain start early");

    property p_capacity;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (level_q == 12'h000) |-> (free_bytes == 12'h800);
    endproperty
    a_capacity: assert property (p_capacity) else $error("capacity not 2048");

    property p_fill_empty;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (level_q == 12'h000) |-> FILL_REQ_OK;
    endproperty
    a_fill_empty: assert property (p_fill_empty) else $error("empty queue blocks fill");

    property p_burst_one;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (cfg_q.burst == 3'h1) |-> (BURST_WORDS == 9'h001);
    endproperty
    a_burst_one: assert property (p_burst_one) else $error("burst 001 not 1");

    property p_burst_six;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (cfg_q.burst == 3'h6) |-> (BURST_WORDS == 9'h020);
    endproperty
    a_burst_six: assert property (p_burst_six) else $error("burst 110 not 32");

    property p_burst_top;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (cfg_q.burst == 3'h7) |-> (BURST_WORDS == 9'h040);
    endproperty
    a_burst_top: assert property (p_burst_top) else $error("burst 111 not 64");

    property p_fill_add;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (FILL_WR && !DRAIN_RD) |=> (level_q == 12'($past(level_q) + $past(FILL_BYTES)));
    endproperty
    a_fill_add: assert property (p_fill_add) else $error("fill bytes not counted");

    property p_drain_sub;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (DRAIN_RD && !FILL_WR) |=> (level_q == 12'($past(level_q) - $past(DRAIN_BYTES)));
    endproperty
    a_drain_sub: assert property (p_drain_sub) else $error("drain bytes not counted");

    property p_pkt_drop;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (DRAIN_RD && DRAIN_PKT_END && !FILL_WR && pkts_q != 8'h00) |=>
            (pkts_q == 8'($past(pkts_q) - 8'h01));
    endproperty
    a_pkt_drop: assert property (p_pkt_drop) else $error("drained packet kept");

endmodule : tx_fifo_threshold_burst_ctrl

// file: hdl/txq_pkg.sv
package txq_pkg;
    // register map
    localparam logic [7:0]  ADDR_TRANSMIT_CONFIG = 8'h00;
    localparam logic [7:0]  ADDR_QUEUE_STATUS    = 8'h04;
    localparam logic [31:0] TRANSMIT_CONFIG_RST  = 32'h0000_0000;
    // field positions
    localparam int BURST_LSB = 20;
    localparam int FILL_LSB  = 8;
    localparam int DRAIN_LSB = 0;
    // only bits 22-20, 13-8 and 5-0 are stored
    localparam logic [31:0] TRANSMIT_CONFIG_MASK = 32'h0070_3F3F;
    // sizing
    localparam int             UNIT_BYTES_LOG2 = 5;
    localparam logic [11:0]    QUEUE_CAPACITY  = 12'h800;
    localparam logic [8:0]     BURST_MAX_WORDS = 9'h080;

    typedef struct packed {
        logic [2:0] burst;
        logic [5:0] fill;
        logic [5:0] drain;
    } tx_cfg_t;
endpackage : txq_pkg

// file: tb/txq_partner.sv
`timescale 1ns/100ps
// stands in for the bus master and transmit engines around the queue
module txq_partner (
    // clock
    input  wire logic        clk,
    // queue traffic
    output logic             fill_wr,
    output logic      [11:0] fill_bytes,
    output logic             fill_end,
    output logic             drain_rd,
    output logic      [11:0] drain_bytes,
    output logic             drain_end
);
    initial {fill_wr, fill_bytes, fill_end, drain_rd, drain_bytes, drain_end} = '0;
    // one transfer per call; caller keeps the level within 0..2048
    task automatic xfer(input logic d, input logic [11:0] n, input logic e);
        @(posedge clk);
        if (d) {drain_rd, drain_bytes, drain_end} <= {1'b1, n, e};
        else {fill_wr, fill_bytes, fill_end} <= {1'b1, n, e};
        @(posedge clk);
        {fill_wr, drain_rd} <= 2'b00;
        {fill_bytes, drain_bytes} <= ~{fill_bytes, drain_bytes};
    endtask : xfer
endmodule : txq_partner

// file: tb/tx_fifo_threshold_burst_ctrl_test.sv
`timescale 1ns/100ps
module tx_fifo_threshold_burst_ctrl_test;
    import txq_pkg::*;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0;
    logic [7:0]  addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        fwr, fend, drd, dend, req_ok, start;
    logic [11:0] fb, db, level;
    logic [8:0]  words;
    int          n_errors = 0, checks = 0;
    initial forever #2 clk = ~clk;
    tx_fifo_threshold_burst_ctrl tx_fifo_threshold_burst_ctrl_inst (.CORE_CLK(clk),
        .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .FILL_WR(fwr), .FILL_BYTES(fb), .FILL_PKT_END(fend),
        .FILL_REQ_OK(req_ok), .BURST_WORDS(words), .DRAIN_RD(drd), .DRAIN_BYTES(db),
        .DRAIN_PKT_END(dend), .DRAIN_START(start), .QUEUE_LEVEL(level));
    txq_partner txq_partner_inst (.clk(clk), .fill_wr(fwr), .fill_bytes(fb), .fill_end(fend),
        .drain_rd(drd), .drain_bytes(db), .drain_end(dend));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp, "read data");
    endtask : rd_reg
    // one queue transfer, then flags and level one cycle later
    task automatic fx(input logic d, input logic [11:0] n, input logic e, input logic ok,
                      input logic st, input logic [11:0] lv);
        txq_partner_inst.xfer(d, n, e);
        #1 chk({18'h0, req_ok, start, level}, {18'h0, ok, st, lv}, "queue flags");
    endtask : fx
    task final_report;
        $display("comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ADDR_TRANSMIT_CONFIG, TRANSMIT_CONFIG_RST);
        chk({req_ok, start, words}, {2'b11, 9'h080}, "reset flags");
        wr_reg(ADDR_TRANSMIT_CONFIG, 32'hFFFF_EAD5);
        rd_reg(ADDR_TRANSMIT_CONFIG, 32'h0070_2A15);
        rd_reg(8'h08, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            wr_reg(ADDR_TRANSMIT_CONFIG, {9'h0, 3'(i), 12'h3E0, 8'h01});
            #1 chk({23'h0, words}, (i == 0) ? 32'h0000_0080 : 32'(1 << (i - 1)), "burst");
        end
        $display("register and burst test done");
        // fill 128 bytes, drain 64 bytes, burst 1 word
        wr_reg(ADDR_TRANSMIT_CONFIG, 32'h0010_0402);
        fx(1'b0, 12'h03F, 1'b0, 1'b1, 1'b0, 12'h03F);
        fx(1'b0, 12'h001, 1'b0, 1'b1, 1'b1, 12'h040);
        fx(1'b0, 12'h740, 1'b0, 1'b1, 1'b1, 12'h780);
        fx(1'b0, 12'h001, 1'b0, 1'b0, 1'b1, 12'h781);
        fx(1'b1, 12'h781, 1'b0, 1'b1, 1'b0, 12'h000);
        fx(1'b0, 12'h00A, 1'b1, 1'b1, 1'b1, 12'h00A);
        rd_reg(ADDR_QUEUE_STATUS, 32'h0000_100A);
        fx(1'b1, 12'h00A, 1'b1, 1'b1, 1'b0, 12'h000);
        $display("threshold test done");
        // reset in mid-run with a packet held clears level, packets and config
        fx(1'b0, 12'h020, 1'b1, 1'b1, 1'b1, 12'h020);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({req_ok, start, words, level}, {2'b11, 9'h080, 12'h000}, "reset again");
        rd_reg(ADDR_QUEUE_STATUS, 32'h0000_0000);
        rd_reg(ADDR_TRANSMIT_CONFIG, TRANSMIT_CONFIG_RST);
        $display("reset test done");
        final_report();
    end
endmodule : tx_fifo_threshold_burst_ctrl_test
